// ===== rtl/valve_supervisor_defines.vh
/*
 Constants for the injector valve and alarm supervisor: register offsets,
 field positions, reset values and timing counts.
 Assumes a 100 MHz hclk and a 32-bit AHB-Lite register bus.
*/
`ifndef VALVE_SUPERVISOR_DEFINES_VH
`define VALVE_SUPERVISOR_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 12'h000
`define OFS_DWELL 12'h004
`define OFS_DOSE 12'h008
`define OFS_LEAK_LIM 12'h00c
`define OFS_LEAK_WIN 12'h010
`define OFS_FLUSH_TGT 12'h014
`define OFS_FLUSH_TOL 12'h018
`define OFS_ACTION 12'h01c
`define OFS_STATUS 12'h020
`define OFS_INT_STAT 12'h024
`define OFS_INT_MASK 12'h028
`define OFS_DELIVERED 12'h02c

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_TAIL_DONE 2
`define CTRL_ALM_CLR 3
`define ACT_LEAK_LO 0
`define ACT_SLOW_LO 2
`define ACT_IGNORE 2'h0
`define ACT_INDICATE 2'h1
`define ACT_SHUTDOWN 2'h2
`define INT_LEAK 0
`define INT_SLOW 1
`define INT_DONE 2
`define INT_SHUT 3
`define DWELL_RST 15'h0000
`define DWELL_MAX 15'h7fff
`define LEAK_LIM_RST 14'h0064
`define LEAK_WIN_RST 7'h3c
`define LEAK_WIN_MIN 7'h01
`define LEAK_WIN_MAX 7'h63
`define FLUSH_TOL_RST 7'h0a
`define FLUSH_TOL_MAX 7'h64
`define ACTION_RST 4'h8

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 100
`define MS_US 1000
`define MS_CYCLES (`CLK_MHZ * `MS_US)
`define SEC_MS 1000

`endif

// ===== rtl/tick_divider.v
/*
 Modulo divider giving a one-cycle enable pulse every DIV input enables.
 Assumes en_in is a one-cycle pulse or tied high, in the hclk domain.
*/
`timescale 1ns/1ps
module tick_divider #(
    parameter integer DIV = 1000
) (
    input wire hclk,
    input wire hresetn,
    input wire en_in,
    output reg tick
);
    reg [19:0] cnt_ff;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_ff <= 20'h00000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (en_in)
            begin
                if (cnt_ff == DIV[19:0] - 20'h00001)
                begin
                    cnt_ff <= 20'h00000;
                    tick <= 1'b1;
                end
                else
                begin
                    cnt_ff <= cnt_ff + 20'h00001;
                end
            end
        end
    end
endmodule // tick_divider

// ===== rtl/alarm_action.v
/*
 Maps one raised alarm through its three-way action to latched
 indication and shutdown flags.
 Assumes raise is a one-cycle pulse; clr is a software clear pulse.
*/
`timescale 1ns/1ps
`include "valve_supervisor_defines.vh"
module alarm_action (
    input wire hclk,
    input wire hresetn,
    input wire [1:0] action,
    input wire raise,
    input wire clr,
    output wire event_out,
    output reg ind_ff,
    output reg shut_ff
);
    // Ignored alarms leave no trace at all
    assign event_out = raise && (action != `ACT_IGNORE); // RQ5

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ind_ff <= 1'b0;
            shut_ff <= 1'b0;
        end
        else
        begin
            // Set wins over clear
            if (event_out)
            begin
                ind_ff <= 1'b1; // RQ6
                shut_ff <= shut_ff | (action == `ACT_SHUTDOWN); // RQ7
            end
            else if (clr)
            begin
                ind_ff <= 1'b0;
                shut_ff <= 1'b0;
            end
        end
    end
endmodule // alarm_action

// ===== rtl/valve_supervisor.v
/*
 Additive injector valve pulsing and alarm supervision for one stream,
 with an AHB-Lite register slave and a level interrupt.
 Assumes meter pulses are one-cycle, synchronous to hclk, one per 0.1 ml
 of additive and one per litre of product.
*/
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
//
// Function
// RQ1 - Nonzero dwell: each open pulse lasts dwell ms, 0..32767, reset zero.
// RQ2 - Pulsed mode: closed time equals open time, stroke twice dwell.
// RQ3 - Zero dwell: open once per cycle until full dose delivered.
// RQ4 - Nonzero dwell: repeat strokes until cycle dose dispensed.
// RQ5 - Each alarm has ignore, indicate or indicate-and-shutdown action.
// RQ6 - Indicate-only alarm sets indication output; transactions continue.
// RQ7 - Shutdown alarm sets both outputs, stops and blocks transactions.
// RQ8 - Accumulate additive over leak window; alarm when above ceiling.
// RQ9 - Leak window 1..99 seconds, default 60.
// RQ10 - Leak check only while idle or between injections.
// RQ11 - Window expiry without alarm clears accumulation, restarts timer.
// RQ12 - Slow-flow alarm when tail volume short of target beyond tolerance.
// RQ13 - Tail is product after injection stops; zero target disables it.
// RQ14 - All ms and s timing from one free-running tick off hclk.
`timescale 1ns/1ps
`include "valve_supervisor_defines.vh"
module valve_supervisor (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire additive_pulse,
    input wire product_pulse,
    output reg valve_open_ff,
    output wire alarm_indicate,
    output wire alarm_shutdown,
    output wire irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_OPEN = 3'b010;
    localparam ST_SHUT = 3'b100;

    // ****************************************
    // Tick generation
    // ****************************************
    wire ms_tick;
    wire sec_tick;

    tick_divider #(.DIV(`MS_CYCLES)) u_ms_div ( // RQ14
        .hclk(hclk),
        .hresetn(hresetn),
        .en_in(1'b1),
        .tick(ms_tick)
    );

    tick_divider #(.DIV(`SEC_MS)) u_sec_div ( // RQ14
        .hclk(hclk),
        .hresetn(hresetn),
        .en_in(ms_tick),
        .tick(sec_tick)
    );

    // ****************************************
    // Register file
    // ****************************************
    reg [14:0] dwell_ff;
    reg [15:0] dose_ff;
    reg [13:0] leak_lim_ff;
    reg [6:0] leak_win_ff;
    reg [15:0] flush_tgt_ff;
    reg [6:0] flush_tol_ff;
    reg [3:0] action_ff;
    reg [3:0] int_stat_ff;
    reg [3:0] int_mask_ff;
    reg [15:0] delivered_ff;
    reg [2:0] state_ff;
    reg ph_wr_ff;
    reg [11:0] ph_addr_ff;

    wire addr_ph = hsel && hready && htrans[1];
    wire wr_hit = ph_wr_ff;
    wire start_wr = wr_hit && (ph_addr_ff == `OFS_CTRL) && hwdata[`CTRL_START];
    wire stop_wr = wr_hit && (ph_addr_ff == `OFS_CTRL) && hwdata[`CTRL_STOP];
    wire tail_wr = wr_hit && (ph_addr_ff == `OFS_CTRL) && hwdata[`CTRL_TAIL_DONE];
    wire alm_clr = wr_hit && (ph_addr_ff == `OFS_CTRL) && hwdata[`CTRL_ALM_CLR];

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Window limited to its legal span on write
    wire [6:0] win_wr = (hwdata[6:0] < `LEAK_WIN_MIN) ? `LEAK_WIN_MIN :
                        (hwdata[6:0] > `LEAK_WIN_MAX) ? `LEAK_WIN_MAX : hwdata[6:0];
    wire [6:0] tol_wr = (hwdata[6:0] > `FLUSH_TOL_MAX) ? `FLUSH_TOL_MAX : hwdata[6:0];

    wire leak_ev;
    wire slow_ev;
    wire done_ev;
    wire shut_ev;
    wire [3:0] int_set = {shut_ev, done_ev, slow_ev, leak_ev};

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr_ff <= 1'b0;
            ph_addr_ff <= 12'h000;
            hrdata <= 32'h00000000;
            dwell_ff <= `DWELL_RST;
            dose_ff <= 16'h0000;
            leak_lim_ff <= `LEAK_LIM_RST;
            leak_win_ff <= `LEAK_WIN_RST;
            flush_tgt_ff <= 16'h0000;
            flush_tol_ff <= `FLUSH_TOL_RST;
            action_ff <= `ACTION_RST;
            int_stat_ff <= 4'h0;
            int_mask_ff <= 4'h0;
        end
        else
        begin
            ph_wr_ff <= addr_ph && hwrite;
            ph_addr_ff <= {haddr[11:2], 2'b00};
            if (addr_ph && !hwrite)
            begin
                case ({haddr[11:2], 2'b00})
                    `OFS_DWELL: hrdata <= {17'h00000, dwell_ff};
                    `OFS_DOSE: hrdata <= {16'h0000, dose_ff};
                    `OFS_LEAK_LIM: hrdata <= {18'h00000, leak_lim_ff};
                    `OFS_LEAK_WIN: hrdata <= {25'h0000000, leak_win_ff};
                    `OFS_FLUSH_TGT: hrdata <= {16'h0000, flush_tgt_ff};
                    `OFS_FLUSH_TOL: hrdata <= {25'h0000000, flush_tol_ff};
                    `OFS_ACTION: hrdata <= {28'h0000000, action_ff};
                    `OFS_STATUS: hrdata <= {26'h0000000, alarm_shutdown, alarm_indicate, valve_open_ff, state_ff};
                    `OFS_INT_STAT: hrdata <= {28'h0000000, int_stat_ff};
                    `OFS_INT_MASK: hrdata <= {28'h0000000, int_mask_ff};
                    `OFS_DELIVERED: hrdata <= {16'h0000, delivered_ff};
                    default: hrdata <= 32'h00000000;
                endcase
            end
            if (wr_hit)
            begin
                case (ph_addr_ff)
                    `OFS_DWELL: dwell_ff <= hwdata[14:0]; // RQ1
                    `OFS_DOSE: dose_ff <= hwdata[15:0];
                    `OFS_LEAK_LIM: leak_lim_ff <= (hwdata[13:0] == 14'h0000) ? 14'h0001 : hwdata[13:0];
                    `OFS_LEAK_WIN: leak_win_ff <= win_wr; // RQ9
                    `OFS_FLUSH_TGT: flush_tgt_ff <= hwdata[15:0];
                    `OFS_FLUSH_TOL: flush_tol_ff <= tol_wr;
                    `OFS_ACTION: action_ff <= hwdata[3:0];
                    `OFS_INT_MASK: int_mask_ff <= hwdata[3:0];
                    default: ;
                endcase
            end
            // Set wins over write-one-to-clear
            if (wr_hit && (ph_addr_ff == `OFS_INT_STAT))
                int_stat_ff <= (int_stat_ff & ~hwdata[3:0]) | int_set;
            else
                int_stat_ff <= int_stat_ff | int_set;
        end
    end

    assign irq = |(int_stat_ff & int_mask_ff);

    // ****************************************
    // Alarm actions
    // ****************************************
    wire leak_raise;
    wire slow_raise;
    wire leak_ind;
    wire leak_shut;
    wire slow_ind;
    wire slow_shut;

    alarm_action u_leak_act (
        .hclk(hclk),
        .hresetn(hresetn),
        .action(action_ff[`ACT_LEAK_LO+1:`ACT_LEAK_LO]),
        .raise(leak_raise),
        .clr(alm_clr),
        .event_out(leak_ev),
        .ind_ff(leak_ind),
        .shut_ff(leak_shut)
    );

    alarm_action u_slow_act (
        .hclk(hclk),
        .hresetn(hresetn),
        .action(action_ff[`ACT_SLOW_LO+1:`ACT_SLOW_LO]),
        .raise(slow_raise),
        .clr(alm_clr),
        .event_out(slow_ev),
        .ind_ff(slow_ind),
        .shut_ff(slow_shut)
    );

    assign alarm_indicate = leak_ind | slow_ind; // RQ6
    assign alarm_shutdown = leak_shut | slow_shut; // RQ7
    // Code 3 acts as indicate, so only the exact shutdown code flags a shutdown event
    assign shut_ev = (leak_ev && (action_ff[`ACT_LEAK_LO+1:`ACT_LEAK_LO] == `ACT_SHUTDOWN)) ||
                     (slow_ev && (action_ff[`ACT_SLOW_LO+1:`ACT_SLOW_LO] == `ACT_SHUTDOWN)); // RQ7

    // ****************************************
    // Injection sequencer
    // ****************************************
    reg [14:0] phase_ms_ff;
    reg [15:0] tail_ff;
    reg tail_run_ff;
    wire dose_met = (delivered_ff >= dose_ff);

    assign done_ev = (state_ff == ST_OPEN) && dose_met && !alarm_shutdown;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= ST_IDLE;
            valve_open_ff <= 1'b0;
            phase_ms_ff <= 15'h0000;
            delivered_ff <= 16'h0000;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    valve_open_ff <= 1'b0;
                    // Start refused while shut down
                    if (start_wr && !alarm_shutdown && (dose_ff != 16'h0000)) // RQ7
                    begin
                        state_ff <= ST_OPEN;
                        valve_open_ff <= 1'b1;
                        phase_ms_ff <= 15'h0000;
                        delivered_ff <= 16'h0000;
                    end
                end
                ST_OPEN:
                begin
                    if (additive_pulse)
                        delivered_ff <= delivered_ff + 16'h0001;
                    if (alarm_shutdown || stop_wr) // RQ7
                    begin
                        state_ff <= ST_SHUT;
                        valve_open_ff <= 1'b0;
                    end
                    else if (dose_met) // RQ3 RQ4
                    begin
                        state_ff <= ST_IDLE;
                        valve_open_ff <= 1'b0;
                    end
                    else if ((dwell_ff != 15'h0000) && ms_tick)
                    begin
                        // Close phase as long as open phase
                        if (phase_ms_ff == dwell_ff - 15'h0001) // RQ1 RQ2
                        begin
                            phase_ms_ff <= 15'h0000;
                            valve_open_ff <= ~valve_open_ff;
                        end
                        else
                            phase_ms_ff <= phase_ms_ff + 15'h0001;
                    end
                end
                ST_SHUT:
                begin
                    valve_open_ff <= 1'b0;
                    state_ff <= ST_IDLE;
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                    valve_open_ff <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Leak watch
    // ****************************************
    reg [13:0] leak_acc_ff;
    reg [6:0] leak_sec_ff;
    // Pulsed mode counts the closed half-strokes too
    wire leak_window_on = (state_ff == ST_IDLE) || (!valve_open_ff && (state_ff == ST_OPEN)); // RQ10
    assign leak_raise = leak_window_on && additive_pulse && (leak_acc_ff == leak_lim_ff); // RQ8

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            leak_acc_ff <= 14'h0000;
            leak_sec_ff <= 7'h00;
        end
        else if (!leak_window_on || leak_raise)
        begin
            leak_acc_ff <= 14'h0000;
            leak_sec_ff <= 7'h00;
        end
        else
        begin
            if (sec_tick && (leak_sec_ff >= leak_win_ff - 7'h01))
            begin
                leak_acc_ff <= 14'h0000; // RQ11
                leak_sec_ff <= 7'h00;
            end
            else
            begin
                if (additive_pulse)
                    leak_acc_ff <= leak_acc_ff + 14'h0001; // RQ8
                if (sec_tick)
                    leak_sec_ff <= leak_sec_ff + 7'h01;
            end
        end
    end

    // ****************************************
    // Flush tail check
    // ****************************************
    // Short by more than tol percent: tail*100 < target*(100-tol)
    wire [22:0] tail_scaled = {7'h00, tail_ff} * 23'h000064;
    wire [22:0] tgt_scaled = {7'h00, flush_tgt_ff} * {16'h0000, `FLUSH_TOL_MAX - flush_tol_ff};
    assign slow_raise = tail_wr && tail_run_ff && (flush_tgt_ff != 16'h0000) && (tail_scaled < tgt_scaled); // RQ12 RQ13

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tail_ff <= 16'h0000;
            tail_run_ff <= 1'b0;
        end
        else if (done_ev || ((state_ff == ST_SHUT)))
        begin
            tail_ff <= 16'h0000; // RQ13
            tail_run_ff <= 1'b1;
        end
        else if (tail_wr)
            tail_run_ff <= 1'b0;
        else if (tail_run_ff && product_pulse && (tail_ff != 16'hffff))
            tail_ff <= tail_ff + 16'h0001;
    end
endmodule // valve_supervisor

// ===== sim/valve_partner.sv
/*
 Valve and meter model: additive pulses while open or leaking, product pulses on request.
 Assumes one-cycle meter pulses in the hclk domain.
*/
`timescale 1ns/1ps
module valve_partner (
    input wire hclk,
    input wire valve_open_ff,
    input wire [1:0] en,
    output reg additive_pulse,
    output reg product_pulse
);
    reg [1:0] cnt_ff = 2'h0;
    initial additive_pulse <= 1'b0;
    initial product_pulse <= 1'b0;
    // Meter rate fixed at one pulse in four cycles
    always @(posedge hclk)
    begin
        cnt_ff <= cnt_ff + 2'h1;
        additive_pulse <= (cnt_ff == 2'h3) && (valve_open_ff || en[0]);
        product_pulse <= (cnt_ff == 2'h3) && en[1];
    end
endmodule // valve_partner

// ===== sim/valve_supervisor_chk.sv
/*
 Port checker for the valve supervisor.
 Assumes hclk and active-low hresetn of the top module.
*/
`timescale 1ns/1ps
module valve_supervisor_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire valve_open_ff,
    input wire alarm_indicate,
    input wire alarm_shutdown
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence shut_on;
        $rose(alarm_shutdown);
    endsequence
    chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_shut_ind: assert property (alarm_shutdown |-> alarm_indicate) else $error("shutdown w/o ind");
    chk_shut_close: assert property (shut_on |-> ##1 !valve_open_ff [*2]) else $error("valve open in shut");
    chk_no_start: assert property ($rose(valve_open_ff) |-> !$past(alarm_shutdown)) else $error("start in shut");
    chk_rdata_hold: assert property (!$stable(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
        else $error("hrdata moved");
    chk_ind_hold: assert property ($fell(alarm_indicate) |-> $past(hwdata[3]) || $past(hwdata[3], 2))
        else $error("ind lost");
    chk_shut_hold: assert property ($fell(alarm_shutdown) |-> $past(hwdata[3]) || $past(hwdata[3], 2))
        else $error("shut lost");
endmodule // valve_supervisor_chk
bind valve_supervisor valve_supervisor_chk valve_supervisor_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .valve_open_ff(valve_open_ff), .alarm_indicate(alarm_indicate),
    .alarm_shutdown(alarm_shutdown));

// ===== sim/tb_top.sv
/*
 Register-level bench of the valve supervisor.
 Assumes the zero-wait slave and 1 ms ticks too slow to test pulsing.
*/
`timescale 1ns/1ps
`include "valve_supervisor_defines.vh"
module tb_top;
    reg hclk, hresetn, hsel, hwrite;
    reg [31:0] haddr, hwdata, q;
    reg [1:0] htrans, en;
    reg [2:0] hsize;
    wire hready, hresp, irq, add_p, prod_p, valve, ind, shut;
    wire [31:0] hrdata;
    int n_fail, n_compared, cyc, i;
    logic [11:0] ofs [8] = '{`OFS_DWELL, `OFS_DOSE, `OFS_LEAK_LIM, `OFS_LEAK_WIN, `OFS_FLUSH_TGT,
        `OFS_FLUSH_TOL, `OFS_ACTION, `OFS_INT_MASK};
    logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h64, 32'h3c, 32'h0, 32'ha, 32'h8, 32'h0};
    valve_supervisor valve_supervisor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .additive_pulse(add_p),
        .product_pulse(prod_p), .valve_open_ff(valve), .alarm_indicate(ind), .alarm_shutdown(shut), .irq(irq));
    valve_partner valve_partner_inst (.hclk(hclk), .valve_open_ff(valve), .en(en),
        .additive_pulse(add_p), .product_pulse(prod_p));
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ****************
    // Tasks
    // ****************
    task finish_test;
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input [31:0] s, input [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    // Returns at the falling edge so flags have settled
    task bus(input w, input [11:0] a, input [31:0] d, output [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
        @(negedge hclk);
    endtask
    task wr_rd(input string nm, input [11:0] a, input [31:0] d, input [31:0] e);
        bus(1'b1, a, d, q);
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask
    task wait_v(input v);
        int j;
        for (j = 0; j < 300 && valve !== v; j++) @(negedge hclk);
        chk("valve", valve, v);
    endtask
    task pulses(input [1:0] sel, input int n);
        int k;
        if (n == 0) return;
        @(posedge hclk) en <= sel;
        k = 0;
        while (k < n)
        begin
            @(negedge hclk);
            if ((sel[0] ? add_p : prod_p) === 1'b1) k++;
        end
        @(posedge hclk) en <= 2'h0;
        repeat (3) @(negedge hclk);
    endtask
    task txn(input int n);
        bus(1'b1, `OFS_CTRL, 32'h1, q);
        wait_v(1'b1);
        wait_v(1'b0);
        pulses(2'h2, n);
        bus(1'b1, `OFS_CTRL, 32'h4, q);
        repeat (2) @(negedge hclk);
    endtask
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test;
        end
    end
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        hresetn <= 1'b0;
        hsel <= 1'b0;
        haddr <= 32'h0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        en <= 2'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            bus(1'b0, ofs[i], 32'h0, q);
            chk("reset", q, rv[i]);
        end
        bus(1'b0, 12'h0fc, 32'h0, q);
        chk("unmapped", q, 32'h0);
        wr_rd("win_lo", `OFS_LEAK_WIN, 32'h0, 32'h1);
        wr_rd("win_hi", `OFS_LEAK_WIN, 32'h64, 32'h63);
        wr_rd("tol_hi", `OFS_FLUSH_TOL, 32'h65, 32'h64);
        wr_rd("dwell", `OFS_DWELL, 32'hffff, 32'h7fff);
        bus(1'b1, `OFS_DWELL, 32'h0, q);
        bus(1'b1, `OFS_FLUSH_TOL, 32'ha, q);
        bus(1'b1, `OFS_ACTION, 32'h0, q);
        bus(1'b1, `OFS_DOSE, 32'h6, q);
        bus(1'b1, `OFS_INT_MASK, 32'h4, q);
        // Zero dwell: one open period for the whole dose
        txn(0);
        bus(1'b0, `OFS_DELIVERED, 32'h0, q);
        chk("delivered", q, 32'h6);
        repeat (20) @(negedge hclk);
        chk("once", valve, 1'b0);
        chk("irq_on", irq, 1'b1);
        bus(1'b1, `OFS_INT_MASK, 32'h0, q);
        chk("irq_mask", irq, 1'b0);
        bus(1'b1, `OFS_INT_MASK, 32'h5, q);
        chk("irq_unmask", irq, 1'b1);
        bus(1'b1, `OFS_INT_STAT, 32'h4, q);
        chk("irq_w1c", irq, 1'b0);
        // Leak: limit 3, alarm on the fourth pulse
        bus(1'b1, `OFS_LEAK_LIM, 32'h3, q);
        bus(1'b1, `OFS_ACTION, 32'h1, q);
        pulses(2'h1, 3);
        chk("leak_at_lim", ind, 1'b0);
        pulses(2'h1, 1);
        chk("leak_ind", ind, 1'b1);
        chk("leak_noshut", shut, 1'b0);
        chk("leak_irq", irq, 1'b1);
        txn(0);
        chk("ind_kept", ind, 1'b1);
        bus(1'b1, `OFS_CTRL, 32'h8, q);
        chk("ind_clr", ind, 1'b0);
        bus(1'b1, `OFS_INT_STAT, 32'hf, q);
        // Slow flow with shutdown action
        // Leak set to indicate: open-valve additive flow must not count as leakage
        bus(1'b1, `OFS_ACTION, 32'h9, q);
        txn(0);
        chk("tgt_zero", shut, 1'b0);
        chk("open_noleak", ind, 1'b0);
        bus(1'b1, `OFS_FLUSH_TGT, 32'ha, q);
        txn(9);
        chk("tail_ok", shut, 1'b0);
        txn(8);
        chk("slow_shut", shut, 1'b1);
        chk("slow_ind", ind, 1'b1);
        bus(1'b0, `OFS_INT_STAT, 32'h0, q);
        chk("int_stat", q, 32'he);
        bus(1'b1, `OFS_CTRL, 32'h1, q);
        repeat (20) @(negedge hclk);
        chk("refused", valve, 1'b0);
        bus(1'b0, `OFS_STATUS, 32'h0, q);
        chk("status", q, 32'h31);
        bus(1'b1, `OFS_CTRL, 32'h8, q);
        chk("shut_clr", shut, 1'b0);
        finish_test;
    end
endmodule // tb_top
